/* rtl/rsc_pin_filter.sv */
// Qualifies the external reset pin against a minimum low time.
// Assumes the pin is already synchronous to the clock.
module rsc_pin_filter #(
  parameter int MIN_CYC = rsc_pkg::PIN_MIN_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic pin_b_i,
  output logic active_o
);

  logic [rsc_pkg::PIN_CNT_W-1:0] cnt_q;
  localparam logic [rsc_pkg::PIN_CNT_W-1:0] LAST =
    rsc_pkg::PIN_CNT_W'(MIN_CYC - 1);

  ////////////////////////////////////////////////////////////////////
  // Saturating low-time counter; a high level restarts it
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || pin_b_i) begin
      cnt_q <= '0;
    end else if (cnt_q != LAST) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Short glitches never reach the combiner
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || pin_b_i) begin
      active_o <= 1'b0;
    end else if (cnt_q == LAST) begin
      active_o <= 1'b1;
    end
  end

  AST_PIN_MIN: assert property (@(posedge ref_clk_i)
    disable iff (!rst_b_i)
    $rose(active_o) |-> !$past(pin_b_i, MIN_CYC))
    else $error("pin reset taken before minimum low time");

endmodule

/* rtl/rsc_stretch.sv */
// Stretch counter: holds internal reset for a fuse-selected number of
// watchdog oscillator ticks after every source has released.
module rsc_stretch #(
  parameter int TICK_DIV = rsc_pkg::TICK_DIV,
  parameter int SHORT_TICKS = rsc_pkg::SHORT_TICKS,
  parameter int LONG_TICKS = rsc_pkg::LONG_TICKS
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic hold_i,
  input wire logic [1:0] delay_sel_i,
  output logic busy_o
);

  localparam int TW = rsc_pkg::TICK_W;
  rsc_pkg::rsc_state_t state_q;
  logic [rsc_pkg::DIV_W-1:0] div_q;
  logic [TW-1:0] cnt_q;
  logic [TW-1:0] target;
  logic tick;
  logic at_end;

  ////////////////////////////////////////////////////////////////////
  // Watchdog oscillator rate as a one-cycle enable
  assign tick = (div_q == rsc_pkg::DIV_W'(TICK_DIV - 1));
  assign at_end = (target == '0) || (cnt_q == target - 1'b1);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  always_comb begin
    case (delay_sel_i)
      rsc_pkg::RSC_DLY_SHORT: target = TW'(SHORT_TICKS);
      rsc_pkg::RSC_DLY_LONG: target = TW'(LONG_TICKS);
      default: target = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state_q <= rsc_pkg::RSC_ST_HOLD;
      cnt_q <= '0;
    end else if (hold_i) begin
      state_q <= rsc_pkg::RSC_ST_HOLD;
      cnt_q <= '0;
    end else begin
      case (state_q)
        rsc_pkg::RSC_ST_HOLD: begin
          state_q <= (target == '0) ? rsc_pkg::RSC_ST_DONE
                                    : rsc_pkg::RSC_ST_COUNT;
        end
        rsc_pkg::RSC_ST_COUNT: begin
          if (tick && cnt_q == target - 1'b1) begin
            state_q <= rsc_pkg::RSC_ST_DONE;
          end else if (tick) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        rsc_pkg::RSC_ST_DONE: state_q <= rsc_pkg::RSC_ST_DONE;
        default: state_q <= rsc_pkg::RSC_ST_HOLD;
      endcase
    end
  end

  assign busy_o = (state_q != rsc_pkg::RSC_ST_DONE);

  AST_STRETCH_END: assert property (@(posedge ref_clk_i)
    disable iff (!rst_b_i)
    $fell(busy_o) |-> $past(at_end))
    else $error("stretch ended before selected tick count");

endmodule

/* rtl/rsc_top.sv */
// Reset source controller: combines four reset sources, stretches the
// internal reset, records the cause and drives the bandgap enable.
// Assumes synchronous inputs and a strobe register port on one clock.
//
// Contract
// - reset loads registers, release starts at vector
// - port reset follows any source without clock; the pin source needs the clock to pass its low-time filter first
// - delay counter stretches reset after release
// - stretch counts 512 or 8192 oscillator ticks; fuse codes 2 and 5 select no stretch
// - exactly four sources: power, pin, watchdog, brownout
// - hold reset while supply below threshold
// - pin reset only after minimum low time
// - watchdog reset needs enable and expiry
// - brownout reset needs enable and low supply
// - cause register bits 7..4 read zero
// - watchdog flag set, cleared by power or zero
// - brownout flag set, cleared by power or zero
// - pin flag set, cleared by power or zero
// - power flag cleared only by writing zero
// - bandgap on for brownout, comparator or converter
//
// Added by the designer: strobed register access and the register addresses.
module rsc_top #(
  parameter int TICK_DIV = rsc_pkg::TICK_DIV,
  parameter int SHORT_TICKS = rsc_pkg::SHORT_TICKS,
  parameter int LONG_TICKS = rsc_pkg::LONG_TICKS,
  parameter int PIN_MIN_CYC = rsc_pkg::PIN_MIN_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic poweron_low_i,
  input wire logic pin_reset_b_i,
  input wire logic wdt_enable_i,
  input wire logic wdt_expire_i,
  input wire logic brownout_enable_i,
  input wire logic brownout_low_i,
  input wire logic comparator_bandgap_select_i,
  input wire logic adc_enable_i,
  input wire logic [1:0] startup_time_fuses_i,
  input wire logic clock_select_fuses_i,
  input wire logic [rsc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [rsc_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [rsc_pkg::DATA_W-1:0] reg_rdata_o,
  output logic port_reset_o,
  output logic internal_reset_o,
  output logic exec_start_o,
  output logic bandgap_enable_o,
  output logic irq_o
);

  localparam int NS = rsc_pkg::NUM_SRC;
  logic [NS-1:0] src;
  logic [NS-1:0] src_q;
  logic [NS-1:0] src_rise;
  logic any_src;
  logic ext_active;
  logic stretch_busy;
  logic [1:0] delay_sel;
  logic [3:0] cause_q;
  logic [3:0] cause_d;
  logic [NS-1:0] irq_stat_q;
  logic [NS-1:0] irq_mask_q;
  logic wr_cause;
  logic wr_stat;
  logic wr_mask;
  logic [rsc_pkg::DATA_W-1:0] rd_mux;

  ////////////////////////////////////////////////////////////////////
  // Source qualification
  rsc_pin_filter #(
    .MIN_CYC(PIN_MIN_CYC)
  ) u_pin (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .pin_b_i(pin_reset_b_i),
    .active_o(ext_active)
  );

  // One bit per source, no more
  always_comb begin
    src = '0;
    src[rsc_pkg::SRC_POR] = poweron_low_i;
    src[rsc_pkg::SRC_EXT] = ext_active;
    src[rsc_pkg::SRC_WDT] = wdt_enable_i & wdt_expire_i;
    src[rsc_pkg::SRC_BOD] = brownout_enable_i & brownout_low_i;
  end

  assign any_src = |src;

  // Combinational path so ports drop even with the clock stopped
  assign port_reset_o = any_src | internal_reset_o;

  ////////////////////////////////////////////////////////////////////
  // Stretch of the internal reset
  assign delay_sel = rsc_pkg::DLY_TABLE[{clock_select_fuses_i,
                                         startup_time_fuses_i, 1'b0} +: 2];

  rsc_stretch #(
    .TICK_DIV(TICK_DIV),
    .SHORT_TICKS(SHORT_TICKS),
    .LONG_TICKS(LONG_TICKS)
  ) u_stretch (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .hold_i(any_src),
    .delay_sel_i(delay_sel),
    .busy_o(stretch_busy)
  );

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      internal_reset_o <= 1'b1;
    end else begin
      internal_reset_o <= any_src | stretch_busy;
    end
  end

  // Release pulse tells the core to fetch from the reset vector
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      exec_start_o <= 1'b0;
    end else begin
      exec_start_o <= internal_reset_o & ~(any_src | stretch_busy);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bandgap reference enable
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      bandgap_enable_o <= 1'b0;
    end else begin
      bandgap_enable_o <= brownout_enable_i | comparator_bandgap_select_i
                          | adc_enable_i;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register decode
  assign wr_cause = reg_wr_i && reg_addr_i == rsc_pkg::ADDR_CAUSE;
  assign wr_stat = reg_wr_i && reg_addr_i == rsc_pkg::ADDR_IRQ_STAT;
  assign wr_mask = reg_wr_i && reg_addr_i == rsc_pkg::ADDR_IRQ_MASK;

  // Cause flags: clear by zero first, then sources set over it.
  // Power-on beats everything: it wipes the other three.
  always_comb begin
    cause_d = cause_q;
    if (wr_cause) begin
      cause_d = cause_q & reg_wdata_i[3:0];
    end
    if (src[rsc_pkg::SRC_POR]) begin
      cause_d = 4'h1;
    end else begin
      if (src[rsc_pkg::SRC_WDT]) begin
        cause_d[rsc_pkg::SRC_WDT] = 1'b1;
      end
      if (src[rsc_pkg::SRC_BOD]) begin
        cause_d[rsc_pkg::SRC_BOD] = 1'b1;
      end
      if (src[rsc_pkg::SRC_EXT]) begin
        cause_d[rsc_pkg::SRC_EXT] = 1'b1;
      end
    end
  end

  // Only the cold start resets this; the internal reset never clears it
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cause_q <= rsc_pkg::CAUSE_RESET;
    end else begin
      cause_q <= cause_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt status, one sticky bit per source onset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      src_q <= '0;
    end else begin
      src_q <= src;
    end
  end

  assign src_rise = src & ~src_q;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      irq_stat_q <= '0;
    end else if (wr_stat) begin
      irq_stat_q <= (irq_stat_q & ~reg_wdata_i[NS-1:0]) | src_rise;
    end else begin
      irq_stat_q <= irq_stat_q | src_rise;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      irq_mask_q <= rsc_pkg::IRQ_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask_q <= reg_wdata_i[NS-1:0];
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////
  // Read path; unmapped offsets and upper cause bits read zero
  always_comb begin
    rd_mux = '0;
    case (reg_addr_i)
      rsc_pkg::ADDR_CAUSE: rd_mux = {4'h0, cause_q};
      rsc_pkg::ADDR_IRQ_STAT: rd_mux[NS-1:0] = irq_stat_q;
      rsc_pkg::ADDR_IRQ_MASK: rd_mux[NS-1:0] = irq_mask_q;
      rsc_pkg::ADDR_STATE: begin
        rd_mux[rsc_pkg::STATE_BIT_RESET] = internal_reset_o;
        rd_mux[rsc_pkg::STATE_BIT_BG] = bandgap_enable_o;
        rd_mux[rsc_pkg::STATE_BIT_DLY +: 2] = delay_sel;
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || !reg_rd_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  // Judged from the pins and the pin filter output, not from the internal source vector
  AST_PORT_FOLLOWS: assert property (@(posedge ref_clk_i)
    disable iff (!rst_b_i)
    poweron_low_i || ext_active || (wdt_enable_i && wdt_expire_i)
    || (brownout_enable_i && brownout_low_i) |-> port_reset_o)
    else $error("port reset low while a source is active");

  AST_QUIET_RELEASE: assert property (@(posedge ref_clk_i)
    disable iff (!rst_b_i)
    $fell(internal_reset_o) |-> !$past(any_src) && !$past(any_src, 2))
    else $error("internal reset released too soon after a source");

  AST_HOLD: assert property (@(posedge ref_clk_i)
    disable iff (!rst_b_i) any_src |=> internal_reset_o [*2])
    else $error("internal reset released during active source");

  AST_START: assert property (@(posedge ref_clk_i)
    disable iff (!rst_b_i) exec_start_o |-> $fell(internal_reset_o))
    else $error("start pulse without reset release");

  AST_POR_HOLD: assert property (@(posedge ref_clk_i)
    disable iff (!rst_b_i) poweron_low_i |=> internal_reset_o)
    else $error("reset not held during low supply");

  AST_RSV_ZERO: assert property (@(posedge ref_clk_i)
    disable iff (!rst_b_i)
    reg_rd_i && reg_addr_i == rsc_pkg::ADDR_CAUSE
    |=> reg_rdata_o[7:4] == 4'h0 && reg_rdata_o[3:0] == $past(cause_q))
    else $error("cause read mismatch");

  AST_WDT_FLAG: assert property (@(posedge ref_clk_i)
    disable iff (!rst_b_i)
    wdt_enable_i && wdt_expire_i && !poweron_low_i
    |=> cause_q[rsc_pkg::SRC_WDT])
    else $error("watchdog flag not set");

  AST_WDT_GATE: assert property (@(posedge ref_clk_i)
    disable iff (!rst_b_i)
    $rose(cause_q[rsc_pkg::SRC_WDT])
    |-> $past(wdt_enable_i) && $past(wdt_expire_i))
    else $error("watchdog flag set without enabled expiry");

  AST_BOD_FLAG: assert property (@(posedge ref_clk_i)
    disable iff (!rst_b_i)
    $rose(cause_q[rsc_pkg::SRC_BOD])
    |-> $past(brownout_enable_i) && $past(brownout_low_i))
    else $error("brownout flag set without enabled brownout");

  AST_EXT_FLAG: assert property (@(posedge ref_clk_i)
    disable iff (!rst_b_i) ext_active && !poweron_low_i
    |=> cause_q[rsc_pkg::SRC_EXT])
    else $error("pin flag not set");

  AST_POR_FLAG: assert property (@(posedge ref_clk_i)
    disable iff (!rst_b_i) poweron_low_i |=> cause_q == 4'h1)
    else $error("power-on flag state wrong");

  AST_KEEP_ONE: assert property (@(posedge ref_clk_i)
    disable iff (!rst_b_i)
    cause_q[rsc_pkg::SRC_POR] && !(wr_cause && !reg_wdata_i[0])
    |=> cause_q[rsc_pkg::SRC_POR])
    else $error("power-on flag lost without zero write");

  AST_BANDGAP: assert property (@(posedge ref_clk_i)
    disable iff (!rst_b_i)
    $past(rst_b_i) |-> bandgap_enable_o == ($past(brownout_enable_i)
      | $past(comparator_bandgap_select_i) | $past(adc_enable_i)))
    else $error("bandgap enable wrong");

endmodule

/* shared/rsc_pkg.sv */
// Constants and types shared by the reset source controller.
// Assumes a single 100 MHz clock and a plain strobe register port.
package rsc_pkg;

  ////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int WDT_OSC_KHZ = 128;
  // Clock cycles per watchdog oscillator tick, rounded down
  localparam int TICK_DIV = CLK_FREQ_KHZ / WDT_OSC_KHZ;
  localparam int SHORT_TICKS = 512;
  localparam int LONG_TICKS = 8192;
  localparam int TICK_W = 14;
  localparam int DIV_W = 12;
  // Least low time on the reset pin, rounded up to whole cycles
  localparam int PIN_MIN_NS = 2500;
  localparam int PIN_MIN_CYC = (PIN_MIN_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int PIN_CNT_W = 12;
  localparam int BG_STARTUP_US = 70;

  ////////////////////////////////////////////////////////////////////
  // Reset sources, bit positions shared with the cause register
  localparam int NUM_SRC = 4;
  localparam int SRC_POR = 0;
  localparam int SRC_EXT = 1;
  localparam int SRC_BOD = 2;
  localparam int SRC_WDT = 3;

  ////////////////////////////////////////////////////////////////////
  // Register map
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] ADDR_CAUSE = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h1;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;
  localparam logic [3:0] ADDR_STATE = 4'h3;
  localparam logic [3:0] CAUSE_RESET = 4'h1;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  localparam int STATE_BIT_RESET = 0;
  localparam int STATE_BIT_BG = 1;
  localparam int STATE_BIT_DLY = 2;

  ////////////////////////////////////////////////////////////////////
  // Stretch selection, indexed by {clock select bit 0, startup fuses}
  typedef enum logic [1:0] {
    RSC_DLY_NONE = 2'h0,
    RSC_DLY_SHORT = 2'h1,
    RSC_DLY_LONG = 2'h2
  } rsc_delay_t;
  localparam logic [15:0] DLY_TABLE = 16'h9249;

  typedef enum logic [2:0] {
    RSC_ST_HOLD = 3'h1,
    RSC_ST_COUNT = 3'h2,
    RSC_ST_DONE = 3'h4
  } rsc_state_t;

endpackage

/* testbench/rsc_src_model.sv */
// Model of the reset sources: supply monitors, reset pin, watchdog.
// Assumes one bench process calls its tasks, one at a time.
module rsc_src_model (
  input wire logic ref_clk_i,
  output logic poweron_low_o,
  output logic pin_reset_b_o,
  output logic wdt_enable_o,
  output logic wdt_expire_o,
  output logic brownout_enable_o,
  output logic brownout_low_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    poweron_low_o = 1'b0;
    pin_reset_b_o = 1'b1;
    wdt_enable_o = 1'b0;
    wdt_expire_o = 1'b0;
    brownout_enable_o = 1'b0;
    brownout_low_o = 1'b0;
  end

  // Kind 0 supply, 1 pin, 2 watchdog, 3 brownout
  task automatic src_set(input int kind, input logic on);
    @(posedge ref_clk_i);
    case (kind)
      0: poweron_low_o <= on;
      // Pin has a pull-up, so release goes high
      1: pin_reset_b_o <= ~on;
      2: wdt_expire_o <= on;
      default: brownout_low_o <= on;
    endcase
  endtask

  task automatic set_en(input logic wdt, input logic brownout_detector);
    @(posedge ref_clk_i);
    wdt_enable_o <= wdt;
    brownout_enable_o <= brownout_detector;
  endtask
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the reset source controller.
// Assumes short stretch and pin parameters; sources come from a model.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 4;
  localparam int SHORT = 4;
  localparam int LONG = 8;
  localparam int PMIN = 5;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic comparator_bandgap_select = 1'b0;
  logic adc = 1'b0;
  logic [2:0] fuse = 3'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic por, pin_b, wdt_en, wdt_exp, bod_en, bod_low;
  logic [7:0] rdata;
  logic port_rst, int_rst, exec, bg, irq;
  int failures = 0;
  int n_compared = 0;
  int seed = 83;
  int n;
  int v;
  int t;

  always #5 ref_clk_i = ~ref_clk_i;

  rsc_src_model u_src (.ref_clk_i(ref_clk_i), .poweron_low_o(por),
    .pin_reset_b_o(pin_b), .wdt_enable_o(wdt_en),
    .wdt_expire_o(wdt_exp), .brownout_enable_o(bod_en),
    .brownout_low_o(bod_low));

  rsc_top #(.TICK_DIV(DIV), .SHORT_TICKS(SHORT), .LONG_TICKS(LONG),
    .PIN_MIN_CYC(PMIN)) u_rsc_top (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i), .poweron_low_i(por), .pin_reset_b_i(pin_b),
    .wdt_enable_i(wdt_en), .wdt_expire_i(wdt_exp),
    .brownout_enable_i(bod_en), .brownout_low_i(bod_low),
    .comparator_bandgap_select_i(comparator_bandgap_select), .adc_enable_i(adc),
    .startup_time_fuses_i(fuse[1:0]), .clock_select_fuses_i(fuse[2]),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .port_reset_o(port_rst),
    .internal_reset_o(int_rst), .exec_start_o(exec),
    .bandgap_enable_o(bg), .irq_o(irq));

  ////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), rdata, e);
  endtask

  task automatic wait_run;
    n = 0;
    while (int_rst !== 1'b0) begin
      @(posedge ref_clk_i);
      #1;
      n++;
      if (n > 2000) begin
        failures++;
        end_sim();
      end
    end
    chk("exec_start", 8'(exec), 8'h01);
  endtask

  // Drives one source for len + 1 cycles and waits out the stretch
  task automatic hit(input int kind, input int len);
    u_src.src_set(kind, 1'b1);
    #1;
    if (kind != 1) chk("port_reset", 8'(port_rst), 8'h01);
    repeat (len) @(posedge ref_clk_i);
    u_src.src_set(kind, 1'b0);
    #1;
    wait_run();
  endtask

  task automatic quiet(input string nm);
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk(nm, 8'(int_rst), 8'h00);
  endtask

  function automatic int sel_of(input int c);
    return (c % 3 == 0) ? 1 : (c % 3 == 1) ? 2 : 0;
  endfunction

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    #1;
    wait_run();
    rd_chk(rsc_pkg::ADDR_CAUSE, 8'h01);
    rd_chk(rsc_pkg::ADDR_IRQ_MASK, 8'h00);
    rd_chk(4'h9, 8'h00);
    wr_reg(rsc_pkg::ADDR_CAUSE, 8'h00);
    rd_chk(rsc_pkg::ADDR_CAUSE, 8'h00);
    // Pin low one cycle short of the minimum
    u_src.src_set(1, 1'b1);
    repeat (PMIN - 2) @(posedge ref_clk_i);
    u_src.src_set(1, 1'b0);
    quiet("short pin");
    rd_chk(rsc_pkg::ADDR_CAUSE, 8'h00);
    hit(1, PMIN + 1);
    rd_chk(rsc_pkg::ADDR_CAUSE, 8'h02);
    rd_chk(rsc_pkg::ADDR_IRQ_STAT, 8'h02);
    chk("irq masked", 8'(irq), 8'h00);
    v = ($random(seed) & 15) | 2;
    wr_reg(rsc_pkg::ADDR_IRQ_MASK, 8'(v));
    #1;
    chk("irq", 8'(irq), 8'h01);
    rd_chk(rsc_pkg::ADDR_IRQ_MASK, 8'(v));
    wr_reg(rsc_pkg::ADDR_IRQ_STAT, 8'h02);
    #1;
    chk("irq clear", 8'(irq), 8'h00);
    wr_reg(rsc_pkg::ADDR_IRQ_MASK, 8'h00);
    // Sources gated by their enables
    u_src.src_set(2, 1'b1);
    u_src.src_set(2, 1'b0);
    quiet("wdt off");
    u_src.set_en(1'b1, 1'b0);
    hit(2, 1);
    rd_chk(rsc_pkg::ADDR_CAUSE, 8'h0A);
    u_src.src_set(3, 1'b1);
    quiet("bod off");
    u_src.src_set(3, 1'b0);
    u_src.set_en(1'b0, 1'b1);
    hit(3, 3);
    rd_chk(rsc_pkg::ADDR_CAUSE, 8'h0E);
    wr_reg(rsc_pkg::ADDR_CAUSE, 8'hFF);
    rd_chk(rsc_pkg::ADDR_CAUSE, 8'h0E);
    wr_reg(rsc_pkg::ADDR_CAUSE, 8'hFB);
    rd_chk(rsc_pkg::ADDR_CAUSE, 8'h0A);
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      @(posedge ref_clk_i);
      comparator_bandgap_select <= v[0];
      adc <= v[1];
      u_src.set_en(1'b0, v[2]);
      // Let the reference enable settle before it is judged
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk("bandgap", 8'(bg), 8'(|v[2:0]));
      rd_chk(rsc_pkg::ADDR_STATE,
        {4'h0, 2'(sel_of(0)), |v[2:0], 1'b0});
    end
    // Stretch length for every fuse code
    for (int c = 0; c < 8; c++) begin
      @(posedge ref_clk_i);
      fuse <= 3'(c);
      hit(0, 3);
      t = (sel_of(c) == 1) ? SHORT * DIV
        : (sel_of(c) == 2) ? LONG * DIV : 0;
      // Free divider phase gives up to one tick of slack
      chk("stretch", 8'(n >= t - DIV + 2 && n <= t + 2), 8'h01);
    end
    rd_chk(rsc_pkg::ADDR_CAUSE, 8'h01);
    hit(1, PMIN + 1);
    rd_chk(rsc_pkg::ADDR_CAUSE, 8'h03);
    end_sim();
  end
endmodule
